// ===== hw/pmcs_consts.svh
// constants for the power mode clock switch controller
// assumes inclusion by bare name from the controller module
// How it works
// RULE1: switch takes two old plus three-four new cycles
// RULE2: three status flags at fixed bit positions
// RULE3: each flag names the clock in use
// RULE4: internal primary may show both flags
// RULE5: each sleep samples idle enable then
// RULE6: run modes clock core and peripherals
// RULE7: reset enters primary run, primary flag set
// RULE8: select 01 goes to secondary oscillator
// RULE9: secondary disabled refuses, not running waits
// RULE10: secondary to primary waits for primary ready
// RULE11: upper select bit enters internal run
// RULE12: all-zero frequency selects slow rc, flag clear
// RULE13: enabling fast osc sets flag after interval
// RULE14: already stable fast osc keeps flag set
// RULE15: internal to primary waits, swaps flags
// RULE16: sleep without idle clears flags, stops osc
// RULE17: sleep keeps rc and secondary osc if enabled
// RULE18: wake waits for selected source ready
// RULE19: avoid internal run with internal primary
// RULE20: idle enable bit 7, select encodes source
// RULE21: new select starts switch at once
// RULE22: idle sleep stops cpu clock, flags kept
// RULE23: status flags are read only
`ifndef PMCS_CONSTS_SVH
`define PMCS_CONSTS_SVH
`define PMCS_OSC_CTRL_ADDR 12'h000
`define PMCS_SEC_CTRL_ADDR 12'h004
`define PMCS_IDLE_BIT 7
`define PMCS_FREQ_HI 6
`define PMCS_FREQ_LO 4
`define PMCS_PRI_FLAG_BIT 3
`define PMCS_INT_FLAG_BIT 2
`define PMCS_SEL_HI 1
`define PMCS_SEL_LO 0
`define PMCS_SRC_SEL_BIT 8
`define PMCS_SEC_FLAG_BIT 6
`define PMCS_SEC_EN_BIT 3
`define PMCS_OLD_CYCLES 3'h2
`define PMCS_NEW_CYCLES 3'h4
`define PMCS_STAB_NS 1000
`define PMCS_CLK_NS 4
`define PMCS_STAB_CYCLES ((`PMCS_STAB_NS + `PMCS_CLK_NS - 1) / `PMCS_CLK_NS)
`endif

// ===== hw/pmcs_pkg.sv
// types for the power mode clock switch controller
// uses nothing from the constants header
`default_nettype none
package pmcs_pkg;
    typedef enum logic [1:0] {
        PMCS_SRC_PRI = 2'h0,
        PMCS_SRC_SEC = 2'h1,
        PMCS_SRC_INT = 2'h2
    } pmcs_src_e;
    // gray order along run, switch, sleep, idle
    typedef enum logic [1:0] {
        PMCS_ST_RUN = 2'h0,
        PMCS_ST_SWITCH = 2'h1,
        PMCS_ST_SLEEP = 2'h3,
        PMCS_ST_IDLE = 2'h2
    } pmcs_state_e;
endpackage : pmcs_pkg
`default_nettype wire

// ===== hw/pmcs_ctrl.sv
// clock source and power mode controller with apb register access
// assumes ready pins of oscillators come from other clock domains
//
// Our own choices: the APB register port and the register offsets.
`include "pmcs_consts.svh"
`default_nettype none
module pmcs_ctrl #(
    parameter int STAB_CYCLES = `PMCS_STAB_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic sleep_exec_in,
    input wire logic wake_in,
    input wire logic two_speed_en_in,
    input wire logic fail_safe_en_in,
    input wire logic wdt_en_in,
    input wire logic pri_is_internal_in,
    input wire logic pri_ready_in,
    input wire logic sec_osc_ready_in,
    input wire logic int_osc_ready_in,
    output logic pri_osc_en_out,
    output logic sec_osc_en_out,
    output logic int_fast_en_out,
    output logic slow_rc_en_out,
    output pmcs_pkg::pmcs_src_e clk_src_out,
    output logic clk_gate_out,
    output logic cpu_clk_en_out,
    output logic periph_clk_en_out
);
    import pmcs_pkg::*;

    typedef struct packed {
        pmcs_state_e st;
        pmcs_src_e cur;
        pmcs_src_e tgt;
        logic [2:0] cnt;
        logic [12:0] stab;
        logic idle_en;
        logic [1:0] sel;
        logic [2:0] freq;
        logic int_src;
        logic sec_en;
        logic pri_flag;
        logic int_flag;
        logic sec_flag;
        logic [1:0] pri_sync;
        logic [1:0] sec_sync;
        logic [1:0] int_sync;
        logic [31:0] rdata;
    } pmcs_state_s;

    pmcs_state_s r;
    pmcs_state_s next_r;

    // selection to source decode, upper bit wins
    function automatic pmcs_src_e sel_src(input logic [1:0] s);
        if (s[1]) begin // RULE11
            return PMCS_SRC_INT;
        end
        return s[0] ? PMCS_SRC_SEC : PMCS_SRC_PRI; // RULE20
    endfunction : sel_src

    // source ready check from synchronised pins
    function automatic logic src_ready(input pmcs_src_e s,
                                       input logic p, input logic q);
        return (s == PMCS_SRC_PRI) ? p : (s == PMCS_SRC_SEC) ? q : 1'b1;
    endfunction : src_ready

    logic pri_rdy;
    logic sec_rdy;
    logic int_rdy;
    logic fast_on;
    logic wr;
    logic rd;
    pmcs_src_e want;
    assign pri_rdy = r.pri_sync[1];
    assign sec_rdy = r.sec_sync[1];
    assign int_rdy = r.int_sync[1];
    assign fast_on = (r.freq != 3'h0) || r.int_src;
    assign wr = psel_in && penable_in && pwrite_in;
    assign rd = psel_in && !pwrite_in;
    assign want = sel_src(r.sel);

    // next state: bus writes, mode machine, status flags
    always_comb begin
        next_r = r;
        next_r.pri_sync = {r.pri_sync[0], pri_ready_in};
        next_r.sec_sync = {r.sec_sync[0], sec_osc_ready_in};
        next_r.int_sync = {r.int_sync[0], int_osc_ready_in};
        // status bits are not writable
        if (wr && paddr_in == `PMCS_OSC_CTRL_ADDR) begin // RULE23
            next_r.idle_en = pwdata_in[`PMCS_IDLE_BIT];
            next_r.freq = pwdata_in[`PMCS_FREQ_HI:`PMCS_FREQ_LO];
            next_r.sel = pwdata_in[`PMCS_SEL_HI:`PMCS_SEL_LO];
            next_r.int_src = pwdata_in[`PMCS_SRC_SEL_BIT];
        end
        if (wr && paddr_in == `PMCS_SEC_CTRL_ADDR) begin
            next_r.sec_en = pwdata_in[`PMCS_SEC_EN_BIT];
        end
        // fast oscillator stabilisation, applies at any time
        if (!fast_on) begin
            next_r.stab = 13'h0;
        end else if (r.stab != 13'(STAB_CYCLES) && int_rdy) begin
            next_r.stab = r.stab + 13'h1; // RULE13
        end
        case (r.st)
            PMCS_ST_RUN: begin
                if (sleep_exec_in) begin
                    // idle enable taken at this instant
                    next_r.st = r.idle_en ? PMCS_ST_IDLE
                                          : PMCS_ST_SLEEP; // RULE5
                    if (!r.idle_en) begin
                        next_r.pri_flag = 1'b0; // RULE16
                        next_r.int_flag = 1'b0;
                        next_r.sec_flag = 1'b0;
                    end
                end else if (want != r.cur &&
                             !(want == PMCS_SRC_SEC && !r.sec_en)) begin
                    next_r.st = PMCS_ST_SWITCH; // RULE21 RULE9
                    next_r.tgt = want;
                    next_r.cnt = 3'h0;
                end
            end
            PMCS_ST_SWITCH: begin
                // stay on outgoing clock until incoming is ready
                if (src_ready(r.tgt, pri_rdy, sec_rdy)) begin // RULE10 RULE15
                    next_r.cnt = r.cnt + 3'h1;
                    if (r.cnt == `PMCS_OLD_CYCLES + `PMCS_NEW_CYCLES
                        - 3'h1) begin // RULE1
                        next_r.st = PMCS_ST_RUN;
                        next_r.cur = r.tgt;
                        next_r.pri_flag = (r.tgt == PMCS_SRC_PRI); // RULE8
                        next_r.sec_flag = (r.tgt == PMCS_SRC_SEC);
                    end
                end
            end
            PMCS_ST_SLEEP: begin
                if (wake_in) begin
                    next_r.st = PMCS_ST_SWITCH; // RULE18
                    next_r.tgt = want;
                    next_r.cnt = 3'h0;
                end
            end
            PMCS_ST_IDLE: begin
                if (wake_in) begin
                    next_r.st = PMCS_ST_RUN; // RULE22
                end
            end
            default: begin
                next_r.st = PMCS_ST_RUN;
            end
        endcase
        // internal flag: stable fast osc feeding the device
        if (next_r.st != PMCS_ST_SLEEP) begin
            next_r.int_flag = fast_on && r.stab == 13'(STAB_CYCLES) &&
                (next_r.cur == PMCS_SRC_INT ||
                 (next_r.cur == PMCS_SRC_PRI &&
                  pri_is_internal_in)); // RULE4 RULE12 RULE14 RULE3
        end
        next_r.rdata = 32'h0;
        if (rd && paddr_in == `PMCS_OSC_CTRL_ADDR) begin
            next_r.rdata[`PMCS_IDLE_BIT] = r.idle_en;
            next_r.rdata[`PMCS_FREQ_HI:`PMCS_FREQ_LO] = r.freq;
            next_r.rdata[`PMCS_PRI_FLAG_BIT] = r.pri_flag; // RULE2
            next_r.rdata[`PMCS_INT_FLAG_BIT] = r.int_flag;
            next_r.rdata[`PMCS_SEL_HI:`PMCS_SEL_LO] = r.sel;
            next_r.rdata[`PMCS_SRC_SEL_BIT] = r.int_src;
        end else if (rd && paddr_in == `PMCS_SEC_CTRL_ADDR) begin
            next_r.rdata[`PMCS_SEC_FLAG_BIT] = r.sec_flag;
            next_r.rdata[`PMCS_SEC_EN_BIT] = r.sec_en;
        end
    end

    // state register, reset to primary run
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            r <= '0;
            r.pri_flag <= 1'b1; // RULE7
        end else begin
            r <= next_r;
        end
    end

    // two-speed start keeps the internal clock after reset
    logic ts_hold;
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ts_hold <= 1'b1;
        end else if (pri_rdy) begin
            ts_hold <= 1'b0;
        end
    end

    // oscillator enables; rc kept for watchdog or monitor
    assign pri_osc_en_out = (r.cur == PMCS_SRC_PRI && r.st != PMCS_ST_SLEEP)
        || (r.tgt == PMCS_SRC_PRI && r.st == PMCS_ST_SWITCH); // RULE8 RULE11
    assign sec_osc_en_out = r.sec_en; // RULE17
    assign int_fast_en_out = fast_on && r.st != PMCS_ST_SLEEP;
    assign slow_rc_en_out = wdt_en_in || fail_safe_en_in ||
        (r.st != PMCS_ST_SLEEP && r.cur == PMCS_SRC_INT && !fast_on); // RULE15
    assign clk_src_out = (two_speed_en_in && ts_hold) ? PMCS_SRC_INT : r.cur;
    // gating in sleep, and while a wake with two-speed start and fail-safe off waits on its own source that is not running
    assign clk_gate_out = (r.st == PMCS_ST_SLEEP) ||
        (r.st == PMCS_ST_SWITCH && r.cur == r.tgt &&
         !(two_speed_en_in || fail_safe_en_in) &&
         !src_ready(r.tgt, pri_rdy, sec_rdy)); // RULE18
    // a wake back to the same source keeps the core stopped until the switch ends
    assign cpu_clk_en_out = r.st == PMCS_ST_RUN ||
        (r.st == PMCS_ST_SWITCH && r.cur != r.tgt); // RULE6 RULE18
    assign periph_clk_en_out = r.st != PMCS_ST_SLEEP;
    assign prdata_out = r.rdata;
    assign pready_out = psel_in && penable_in;
    assign pslverr_out = psel_in && penable_in &&
        paddr_in != `PMCS_OSC_CTRL_ADDR && paddr_in != `PMCS_SEC_CTRL_ADDR;

    AST_SLEEP_CLEARS: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        r.st == PMCS_ST_RUN && sleep_exec_in && !r.idle_en |=>
        r.st == PMCS_ST_SLEEP && !r.pri_flag && !r.sec_flag) // RULE16
        else $error("sleep entry did not clear flags");
    AST_IDLE_KEEPS: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        r.st == PMCS_ST_RUN && sleep_exec_in && r.idle_en |=>
        r.st == PMCS_ST_IDLE && $stable(r.pri_flag)) // RULE22
        else $error("idle entry changed flags");
    AST_SEC_REFUSE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        r.st == PMCS_ST_RUN && r.sel == 2'h1 && !r.sec_en && !sleep_exec_in
        |=> r.st == PMCS_ST_RUN) // RULE9
        else $error("secondary entry not refused");
    AST_SWITCH_LEN: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        r.st == PMCS_ST_SWITCH && r.cnt == 3'h5 &&
        src_ready(r.tgt, pri_rdy, sec_rdy) |=> r.st == PMCS_ST_RUN) // RULE1
        else $error("switch length wrong");
    AST_SEC_FLAGS: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        r.st == PMCS_ST_RUN && r.cur == PMCS_SRC_SEC |->
        r.sec_flag && !r.pri_flag) // RULE8
        else $error("secondary flags wrong");
    AST_PRI_FLAG: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        r.st == PMCS_ST_RUN && r.cur == PMCS_SRC_PRI |->
        r.pri_flag && !r.sec_flag) // RULE7
        else $error("primary flag not set");
    AST_INT_ZERO: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        r.freq == 3'h0 && !r.int_src ##1 r.freq == 3'h0 && !r.int_src
        |-> !r.int_flag) // RULE12
        else $error("internal flag set while disabled");
    AST_WAKE_SW: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        r.st == PMCS_ST_SLEEP && wake_in |=>
        r.st == PMCS_ST_SWITCH && r.cnt == 3'h0) // RULE18
        else $error("wake did not start source wait");
    AST_SEL_GO: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        r.st == PMCS_ST_RUN && !sleep_exec_in && r.sel[1] &&
        r.cur != PMCS_SRC_INT |=> r.st == PMCS_ST_SWITCH &&
        r.tgt == PMCS_SRC_INT) // RULE11 RULE21
        else $error("internal select did not switch");

    // sleep gates core and peripheral clocks alike
    AST_SLEEP_GATED: assert property (@(posedge sys_clk_in) // RULE16
        disable iff (rst_in)
        r.st == PMCS_ST_SLEEP |-> !cpu_clk_en_out && !periph_clk_en_out)
        else $error("clock live in sleep");

    // idle keeps peripherals running, core stopped
    AST_IDLE_CLK: assert property (@(posedge sys_clk_in) // RULE22
        disable iff (rst_in)
        r.st == PMCS_ST_IDLE |-> !cpu_clk_en_out && periph_clk_en_out)
        else $error("idle clocking wrong");

    // every run mode clocks both domains
    AST_RUN_CLK: assert property (@(posedge sys_clk_in) // RULE6
        disable iff (rst_in)
        r.st == PMCS_ST_RUN |-> cpu_clk_en_out && periph_clk_en_out)
        else $error("run mode clock missing");

    // primary oscillator stopped while on the internal block
    AST_PRI_STOP_INT: assert property (@(posedge sys_clk_in) // RULE11
        disable iff (rst_in)
        r.st == PMCS_ST_RUN && r.cur == PMCS_SRC_INT |-> !pri_osc_en_out)
        else $error("primary left on in internal run");

    // primary oscillator stopped while on the secondary
    AST_PRI_STOP_SEC: assert property (@(posedge sys_clk_in) // RULE8
        disable iff (rst_in)
        r.st == PMCS_ST_RUN && r.cur == PMCS_SRC_SEC |-> !pri_osc_en_out)
        else $error("primary left on in secondary run");

    // slow rc never dropped under watchdog or monitor
    AST_RC_KEEP: assert property (@(posedge sys_clk_in) // RULE15 RULE17
        disable iff (rst_in)
        wdt_en_in || fail_safe_en_in |-> slow_rc_en_out)
        else $error("slow rc stopped");

    // secondary oscillator follows its enable, sleep or not
    AST_SEC_KEEP: assert property (@(posedge sys_clk_in) // RULE17
        disable iff (rst_in)
        r.sec_en |-> sec_osc_en_out)
        else $error("secondary oscillator stopped");

    // no status flag survives in sleep
    AST_SLEEP_FLAGS: assert property (@(posedge sys_clk_in) // RULE16
        disable iff (rst_in)
        r.st == PMCS_ST_SLEEP |-> !r.pri_flag && !r.sec_flag && !r.int_flag)
        else $error("flag set in sleep");

    // fast oscillator off during sleep
    AST_SLEEP_FAST_OFF: assert property (@(posedge sys_clk_in) // RULE16
        disable iff (rst_in)
        r.st == PMCS_ST_SLEEP |-> !int_fast_en_out)
        else $error("fast oscillator on in sleep");

    // wake leaves the control bits alone
    AST_WAKE_SEL_KEEP: assert property (@(posedge sys_clk_in) // RULE18
        disable iff (rst_in)
        r.st == PMCS_ST_SLEEP && wake_in && !wr |=>
        $stable(r.sel) && $stable(r.idle_en))
        else $error("wake changed control bits");

    // outgoing clock kept while the incoming one is not ready
    AST_SWITCH_HOLD: assert property (@(posedge sys_clk_in) // RULE10 RULE15
        disable iff (rst_in)
        r.st == PMCS_ST_SWITCH && !src_ready(r.tgt, pri_rdy, sec_rdy) |=>
        r.st == PMCS_ST_SWITCH && $stable(r.cnt))
        else $error("switch ran before source ready");

    // internal flag cannot appear with the fast oscillator off
    AST_INT_FLAG_OFF: assert property (@(posedge sys_clk_in) // RULE13
        disable iff (rst_in)
        !fast_on |=> !r.int_flag)
        else $error("internal flag without fast osc");

    // internal flag waits out the whole stabilise interval
    AST_STAB_WAIT: assert property (@(posedge sys_clk_in) // RULE13
        disable iff (rst_in)
        fast_on && r.stab != 13'(STAB_CYCLES) |=> !r.int_flag)
        else $error("internal flag before stable");

    // arriving on primary swaps the flags over
    AST_PRI_ARRIVE: assert property (@(posedge sys_clk_in) // RULE10 RULE15
        disable iff (rst_in)
        r.st == PMCS_ST_SWITCH && r.tgt == PMCS_SRC_PRI && r.cnt == 3'h5 &&
        src_ready(r.tgt, pri_rdy, sec_rdy) && !pri_is_internal_in |=>
        r.pri_flag && !r.sec_flag && !r.int_flag)
        else $error("primary arrival flags wrong");

    // run without a sleep leaves source flags untouched
    AST_FLAGS_RO: assert property (@(posedge sys_clk_in) // RULE23
        disable iff (rst_in)
        r.st == PMCS_ST_RUN && !sleep_exec_in |=>
        $stable(r.pri_flag) && $stable(r.sec_flag))
        else $error("flag changed outside an event");

    // current source moves only at the end of a switch
    AST_CUR_FIXED: assert property (@(posedge sys_clk_in) // RULE21
        disable iff (rst_in)
        r.st != PMCS_ST_SWITCH |=> $stable(r.cur))
        else $error("source changed outside switch");
endmodule : pmcs_ctrl
`default_nettype wire

// ===== testbench/pmcs_osc_model.sv
// oscillator stand-in: each ready rises some cycles after its enable
// assumes the controller's system clock paces the start-up counts
`default_nettype none
module pmcs_osc_model #(
    parameter int PRI_DLY = 6,
    parameter int SEC_DLY = 9
) (
    input wire logic clk_in,
    input wire logic pri_en_in,
    input wire logic sec_en_in,
    input wire logic fast_en_in,
    output logic pri_ready_out,
    output logic sec_ready_out,
    output logic fast_ready_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int pri_cnt = 0;
    int sec_cnt = 0;
    int fast_cnt = 0;
    // ready drops on the first clock edge with the enable low, so a stale high never leaks
    always @(posedge clk_in) begin
        pri_cnt <= pri_en_in ? pri_cnt + 1 : 0;
        sec_cnt <= sec_en_in ? sec_cnt + 1 : 0;
        fast_cnt <= fast_en_in ? fast_cnt + 1 : 0;
    end
    assign pri_ready_out = pri_cnt > PRI_DLY;
    // slow start of the secondary oscillator
    assign sec_ready_out = sec_cnt > SEC_DLY;
    assign fast_ready_out = fast_cnt > 3;
endmodule : pmcs_osc_model
`default_nettype wire

// ===== testbench/test_power_mode_clock_switch.sv
// self-checking bench for the clock switch controller
// assumes the oscillator model is compiled before this file
`default_nettype none
module test_power_mode_clock_switch import pmcs_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, err, slp = 0, wake = 0, pri_rdy, sec_rdy, f_rdy;
    logic pri_en, sec_en, fast_en, rc_en, gate, cpu_en, per_en;
    pmcs_src_e src;
    int fail_count = 0, n_compared = 0, ctl = 0, sec = 0, flg = 8, f, g;
    pmcs_ctrl #(.STAB_CYCLES(4)) pmcs_ctrl_i (.sys_clk_in(sys_clk_in),
        .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .sleep_exec_in(slp), .wake_in(wake), .two_speed_en_in(1'b0),
        .fail_safe_en_in(1'b0), .wdt_en_in(1'b0),
        .pri_is_internal_in(1'b0), .pri_ready_in(pri_rdy),
        .sec_osc_ready_in(sec_rdy), .int_osc_ready_in(f_rdy),
        .pri_osc_en_out(pri_en), .sec_osc_en_out(sec_en),
        .int_fast_en_out(fast_en), .slow_rc_en_out(rc_en),
        .clk_src_out(src), .clk_gate_out(gate), .cpu_clk_en_out(cpu_en),
        .periph_clk_en_out(per_en));
    pmcs_osc_model pmcs_osc_model_i (.clk_in(sys_clk_in),
        .pri_en_in(pri_en), .sec_en_in(sec_en), .fast_en_in(fast_en),
        .pri_ready_out(pri_rdy), .sec_ready_out(sec_rdy),
        .fast_ready_out(f_rdy));
    // 250 mhz system clock
    initial begin
        forever #2 sys_clk_in = ~sys_clk_in;
    end
    task finish_test;
        if (fail_count == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one apb transfer, held until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge sys_clk_in);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_in);
        penable <= 1;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk_in);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            fail_count++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    // both registers against the model's control and flag copies
    task chk_regs;
        apb(0, 12'h000, 0);
        check(rd, ctl | (flg & 'h0c));
        apb(0, 12'h004, 0);
        check(rd, sec | (flg & 'h40));
    endtask : chk_regs
    task wait_src(input pmcs_src_e s, input logic c);
        int i;
        for (i = 0; i < 300; i++) begin
            @(posedge sys_clk_in);
            if (src === s && cpu_en === c) break;
        end
        if (i == 300) begin
            fail_count++;
            finish_test();
        end
        repeat (2) @(posedge sys_clk_in);
    endtask : wait_src
    task pulse(input bit s);
        @(posedge sys_clk_in);
        if (s) slp <= 1;
        else wake <= 1;
        @(posedge sys_clk_in);
        slp <= 0;
        wake <= 0;
        repeat (3) @(posedge sys_clk_in);
    endtask : pulse
    initial begin
        void'($urandom(1));
        repeat (16) @(posedge sys_clk_in);
        rst_in <= 0;
        chk_regs();
        check(32'(cpu_en & per_en), 1);
        apb(1, 12'h000, 'h0c);
        chk_regs();
        apb(0, 12'h010, 0);
        check({rd[30:0], err}, 1);
        // secondary select with its oscillator off must not switch
        apb(1, 12'h000, 1);
        repeat (30) @(posedge sys_clk_in);
        check(32'(src), 0);
        apb(1, 12'h000, 0);
        sec = 8;
        apb(1, 12'h004, sec);
        ctl = 1;
        apb(1, 12'h000, ctl);
        wait_src(PMCS_SRC_SEC, 1);
        flg = 'h40;
        chk_regs();
        check(32'(pri_en), 0);
        ctl = 0;
        apb(1, 12'h000, ctl);
        wait_src(PMCS_SRC_PRI, 1);
        flg = 8;
        chk_regs();
        check(32'(sec_en), 1);
        f = $urandom_range(7, 1);
        g = f % 7 + 1;
        ctl = (f << 4) | 2;
        apb(1, 12'h000, ctl);
        wait_src(PMCS_SRC_INT, 1);
        check(32'(pri_en), 0);
        repeat (20) @(posedge sys_clk_in);
        flg = 4;
        chk_regs();
        ctl = (g << 4) | 3;
        apb(1, 12'h000, ctl);
        chk_regs();
        ctl = 2;
        apb(1, 12'h000, ctl);
        repeat (3) @(posedge sys_clk_in);
        flg = 0;
        chk_regs();
        check(32'(fast_en), 0);
        check(32'(rc_en), 1);
        ctl = 0;
        apb(1, 12'h000, ctl);
        wait_src(PMCS_SRC_PRI, 1);
        flg = 8;
        chk_regs();
        pulse(1);
        check({cpu_en, per_en}, 0);
        check(32'(gate), 1);
        flg = 0;
        chk_regs();
        pulse(0);
        wait_src(PMCS_SRC_PRI, 1);
        flg = 8;
        chk_regs();
        ctl = 'h80;
        apb(1, 12'h000, ctl);
        pulse(1);
        check({cpu_en, per_en}, 1);
        chk_regs();
        pulse(0);
        wait_src(PMCS_SRC_PRI, 1);
        chk_regs();
        finish_test();
    end
endmodule : test_power_mode_clock_switch
`default_nettype wire
